// ==== src/pcs_mgmt_pkg.sv ====
// Constants shared by the PCS management register bank.
// Assumes a 9-bit word offset and 16-bit register data on the management port.
`default_nettype none
package pcs_mgmt_pkg;

    localparam int          ADDR_WIDTH            = 9;
    localparam int          DATA_WIDTH            = 16;

    localparam logic [8:0]  OFS_PCS_CONTROL       = 9'h000;
    localparam logic [8:0]  OFS_PCS_STATUS        = 9'h001;
    localparam logic [8:0]  OFS_ADVERTISED        = 9'h004;
    localparam logic [8:0]  OFS_PARTNER           = 9'h005;
    localparam logic [8:0]  OFS_AUTONEG_EXPANSION = 9'h006;
    localparam logic [8:0]  OFS_EVENT_STATUS      = 9'h008;
    localparam logic [8:0]  OFS_EVENT_ENABLE      = 9'h009;
    localparam logic [8:0]  OFS_EVENT_FORCE_SET   = 9'h00a;
    localparam logic [8:0]  OFS_CONFIG_SOURCE     = 9'h00e;
    localparam logic [8:0]  OFS_EXTENDED_STATUS   = 9'h00f;
    localparam logic [8:0]  OFS_RECOVERY_FIRST    = 9'h010;
    localparam logic [8:0]  OFS_RECOVERY_LAST     = 9'h01c;
    localparam int          RECOVERY_COUNT        = 13;
    localparam logic [8:0]  OFS_DEBUG_CONTROL_0   = 9'h100;
    localparam logic [8:0]  OFS_DEBUG_CONTROL_1   = 9'h101;
    localparam logic [8:0]  OFS_FIFO_STATUS       = 9'h109;
    localparam logic [8:0]  OFS_DEBUG_CONTROL_10  = 9'h10a;
    localparam logic [8:0]  OFS_DEBUG_CONTROL_11  = 9'h10b;

    // Control register field positions.
    localparam int          CTRL_RESET_BIT        = 15;
    localparam int          CTRL_LOOPBACK_BIT     = 14;
    localparam int          CTRL_SPEED_LOW_BIT    = 13;
    localparam int          CTRL_AUTONEG_EN_BIT   = 12;
    localparam int          CTRL_POWER_DOWN_BIT   = 11;
    localparam int          CTRL_ISOLATE_BIT      = 10;
    localparam int          CTRL_RESTART_BIT      = 9;
    localparam int          CTRL_DUPLEX_BIT       = 8;
    localparam int          CTRL_COLLISION_BIT    = 7;
    localparam int          CTRL_SPEED_HIGH_BIT   = 6;
    localparam int          CTRL_UNIDIR_BIT       = 5;
    localparam logic [15:0] CTRL_WRITABLE_MASK    = 16'hffe0;

    // Status register field positions and constant bits.
    localparam int          STAT_AUTONEG_DONE_BIT = 5;
    localparam int          STAT_LINK_BIT         = 2;
    localparam logic [15:0] STAT_FIXED_BITS       = 16'h0188;

    // Advertised ability rate field.
    localparam int          ADV_RATE_HIGH_BIT     = 11;
    localparam int          ADV_RATE_LOW_BIT      = 10;

    localparam int          CFG_SOURCE_BIT        = 0;

    localparam logic [1:0]  SPEED_10M             = 2'b00;
    localparam logic [1:0]  SPEED_100M            = 2'b01;
    localparam logic [1:0]  SPEED_1G              = 2'b10;
    localparam logic [1:0]  SPEED_RESERVED        = 2'b11;

    localparam logic [15:0] CTRL_RESET_VALUE      = 16'h0000;
    localparam logic [15:0] ADV_RESET_VALUE       = 16'h0000;
    localparam logic [15:0] CFG_RESET_VALUE       = 16'h0000;
    localparam logic [15:0] REG_RESET_VALUE       = 16'h0000;

endpackage
`default_nettype wire

// ==== src/event_bank.sv ====
// Sticky event status with enable and force-set, for the management bank.
// Assumes one-cycle write strobes from the register decoder.
`timescale 1ns/1ns
`default_nettype none
module event_bank (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [15:0] core_events,
    input  wire logic        clear_write,
    input  wire logic        enable_write,
    input  wire logic        force_write,
    input  wire logic [15:0] wdata,
    output logic      [15:0] status_q,
    output logic      [15:0] enable_q,
    output logic             pending_q
);

    logic [15:0] status_d;

    // Setting wins over write-one-to-clear, so no event is lost.
    always_comb begin
        status_d = status_q & ~(clear_write ? wdata : 16'h0000);
        status_d = status_d | core_events;
        status_d = status_d | (force_write ? wdata : 16'h0000);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status_q <= pcs_mgmt_pkg::REG_RESET_VALUE;
        end else begin
            status_q <= status_d;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            enable_q <= pcs_mgmt_pkg::REG_RESET_VALUE;
        end else if (enable_write) begin
            enable_q <= wdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pending_q <= 1'b0;
        end else begin
            pending_q <= |(status_q & enable_q);
        end
    end

    property p_force_sets;
        @(posedge clk) disable iff (rst)
        force_write |=> ((status_q & $past(wdata)) == $past(wdata));
    endproperty
    a_force_sets: assert property (p_force_sets) else $error("force-set write did not set status bits");

    property p_event_sticky;
        @(posedge clk) disable iff (rst)
        (core_events != 16'h0000) |=> ((status_q & $past(core_events)) == $past(core_events));
    endproperty
    a_event_sticky: assert property (p_event_sticky) else $error("core event was not recorded");

    property p_enable_signals;
        @(posedge clk) disable iff (rst)
        ((status_q & enable_q) != 16'h0000) |=> pending_q;
    endproperty
    a_enable_signals: assert property (p_enable_signals) else $error("enabled event did not signal");

endmodule
`default_nettype wire

// ==== src/link_latch.sv ====
// Latch-low link status bit, refreshed by a read of the status register.
// Assumes status_read is a one-cycle strobe at the accepting edge of the read.
`timescale 1ns/1ns
`default_nettype none
module link_latch (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic link_up,
    input  wire logic status_read,
    output logic      link_status_q
);

    // A loss in the same cycle as a read wins, so the drop is still reported.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            link_status_q <= 1'b0;
        end else if (!link_up) begin
            link_status_q <= 1'b0;
        end else if (status_read) begin
            link_status_q <= 1'b1;
        end
    end

    property p_link_loss_latches;
        @(posedge clk) disable iff (rst)
        !link_up |=> !link_status_q;
    endproperty
    a_link_loss_latches: assert property (p_link_loss_latches) else $error("link loss not latched");

    property p_link_held_low;
        @(posedge clk) disable iff (rst)
        (!link_status_q && !status_read) |=> !link_status_q;
    endproperty
    a_link_held_low: assert property (p_link_held_low) else $error("link bit rose without a read");

    property p_link_read_refresh;
        @(posedge clk) disable iff (rst)
        (status_read && link_up) |=> link_status_q;
    endproperty
    a_link_read_refresh: assert property (p_link_read_refresh) else $error("read did not refresh link bit");

endmodule
`default_nettype wire

// ==== src/pcs_management_registers.sv ====
// Management register bank of a gigabit / SGMII PCS: decode, storage and control outputs.
// Assumes a simple memory-mapped management port whose requests are synchronous to clk.
`timescale 1ns/1ns
`default_nettype none
module pcs_management_registers (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          mgmt_request,
    input  wire logic          mgmt_write,
    input  wire logic [8:0]    mgmt_offset,
    input  wire logic [15:0]   mgmt_wdata,
    output logic               mgmt_ready,
    output logic               mgmt_rdata_valid,
    output logic      [15:0]   mgmt_rdata,
    input  wire logic          gbe_mode,
    input  wire logic          link_up,
    input  wire logic          autoneg_complete,
    input  wire logic [15:0]   partner_ability_in,
    input  wire logic [15:0]   autoneg_expansion_in,
    input  wire logic [15:0]   extended_status_in,
    input  wire logic [15:0]   fifo_state_in,
    input  wire logic [15:0]   core_events,
    output logic               core_reset,
    output logic               loopback_enable,
    output logic               power_down,
    output logic               isolate,
    output logic               autoneg_enable,
    output logic               autoneg_restart,
    output logic               duplex_full,
    output logic               collision_test,
    output logic               unidirectional,
    output logic      [1:0]    mii_rate,
    output logic      [15:0]   advertised_ability,
    output logic               internal_config_sel,
    output logic               events_flagged,
    output logic      [207:0]  recovery_config,
    output logic      [15:0]   debug_control_0,
    output logic      [15:0]   debug_control_1,
    output logic      [15:0]   debug_control_10,
    output logic      [15:0]   debug_control_11
);

    logic        wr_req;
    logic        rd_req;
    logic [15:0] ctrl_q;
    logic [15:0] adv_q;
    logic [15:0] cfg_q;
    logic [15:0] dbg0_q;
    logic [15:0] dbg1_q;
    logic [15:0] dbg10_q;
    logic [15:0] dbg11_q;
    logic [15:0] recovery_q [0:12];
    logic [15:0] event_status;
    logic [15:0] event_enable;
    logic        link_status;
    logic [15:0] rdata_d;
    logic        mapped;
    logic [15:0] rdata_q;
    logic        rvalid_q;
    logic [1:0]  rate_d;
    logic [1:0]  rate_q;
    logic [1:0]  speed_code;
    logic [3:0]  recovery_index;
    logic        recovery_hit;

    // Exact match of the request offset against one register.
    function automatic logic hit(input logic [8:0] offset, input logic [8:0] target);
        hit = (offset == target);
    endfunction

    // Speed code as the host sees it; gigabit mode pins it to the one-gigabit code.
    function automatic logic [1:0] speed_of(input logic [15:0] ctrl, input logic gbe);
        if (gbe) begin
            speed_of = pcs_mgmt_pkg::SPEED_1G;
        end else begin
            speed_of = {ctrl[pcs_mgmt_pkg::CTRL_SPEED_HIGH_BIT], ctrl[pcs_mgmt_pkg::CTRL_SPEED_LOW_BIT]};
        end
    endfunction

    // The port never stalls, so requests are taken on every edge they are present.
    assign mgmt_ready = 1'b1;
    assign wr_req     = mgmt_request && mgmt_write;
    assign rd_req     = mgmt_request && !mgmt_write;

    assign recovery_hit   = (mgmt_offset >= pcs_mgmt_pkg::OFS_RECOVERY_FIRST) &&
                            (mgmt_offset <= pcs_mgmt_pkg::OFS_RECOVERY_LAST);
    assign recovery_index = 4'(mgmt_offset - pcs_mgmt_pkg::OFS_RECOVERY_FIRST);

    // Self-clearing bits stay set for exactly one cycle after the write that sets them.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= pcs_mgmt_pkg::CTRL_RESET_VALUE;
        end else if (wr_req && hit(mgmt_offset, pcs_mgmt_pkg::OFS_PCS_CONTROL)) begin
            ctrl_q <= mgmt_wdata & pcs_mgmt_pkg::CTRL_WRITABLE_MASK;
        end else begin
            ctrl_q[pcs_mgmt_pkg::CTRL_RESET_BIT]   <= 1'b0;
            ctrl_q[pcs_mgmt_pkg::CTRL_RESTART_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            adv_q <= pcs_mgmt_pkg::ADV_RESET_VALUE;
        end else if (wr_req && hit(mgmt_offset, pcs_mgmt_pkg::OFS_ADVERTISED)) begin
            adv_q <= mgmt_wdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cfg_q <= pcs_mgmt_pkg::CFG_RESET_VALUE;
        end else if (wr_req && hit(mgmt_offset, pcs_mgmt_pkg::OFS_CONFIG_SOURCE)) begin
            cfg_q <= mgmt_wdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dbg0_q  <= pcs_mgmt_pkg::REG_RESET_VALUE;
            dbg1_q  <= pcs_mgmt_pkg::REG_RESET_VALUE;
            dbg10_q <= pcs_mgmt_pkg::REG_RESET_VALUE;
            dbg11_q <= pcs_mgmt_pkg::REG_RESET_VALUE;
        end else if (wr_req) begin
            if (hit(mgmt_offset, pcs_mgmt_pkg::OFS_DEBUG_CONTROL_0)) begin
                dbg0_q <= mgmt_wdata;
            end
            if (hit(mgmt_offset, pcs_mgmt_pkg::OFS_DEBUG_CONTROL_1)) begin
                dbg1_q <= mgmt_wdata;
            end
            if (hit(mgmt_offset, pcs_mgmt_pkg::OFS_DEBUG_CONTROL_10)) begin
                dbg10_q <= mgmt_wdata;
            end
            if (hit(mgmt_offset, pcs_mgmt_pkg::OFS_DEBUG_CONTROL_11)) begin
                dbg11_q <= mgmt_wdata;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < pcs_mgmt_pkg::RECOVERY_COUNT; i++) begin
                recovery_q[i] <= pcs_mgmt_pkg::REG_RESET_VALUE;
            end
        end else if (wr_req && recovery_hit) begin
            recovery_q[recovery_index] <= mgmt_wdata;
        end
    end

    event_bank u_events (
        .clk          (clk),
        .rst          (rst),
        .core_events  (core_events),
        .clear_write  (wr_req && hit(mgmt_offset, pcs_mgmt_pkg::OFS_EVENT_STATUS)),
        .enable_write (wr_req && hit(mgmt_offset, pcs_mgmt_pkg::OFS_EVENT_ENABLE)),
        .force_write  (wr_req && hit(mgmt_offset, pcs_mgmt_pkg::OFS_EVENT_FORCE_SET)),
        .wdata        (mgmt_wdata),
        .status_q     (event_status),
        .enable_q     (event_enable),
        .pending_q    (events_flagged)
    );

    link_latch u_link (
        .clk           (clk),
        .rst           (rst),
        .link_up       (link_up),
        .status_read   (rd_req && hit(mgmt_offset, pcs_mgmt_pkg::OFS_PCS_STATUS)),
        .link_status_q (link_status)
    );

    assign speed_code = speed_of(ctrl_q, gbe_mode);

    // Read decode; anything not listed, reserved bits included, returns zero.
    always_comb begin
        rdata_d = 16'h0000;
        mapped  = 1'b1;
        if (recovery_hit) begin
            rdata_d = recovery_q[recovery_index];
        end else begin
            case (mgmt_offset)
                pcs_mgmt_pkg::OFS_PCS_CONTROL: begin
                    rdata_d = ctrl_q;
                    rdata_d[pcs_mgmt_pkg::CTRL_SPEED_HIGH_BIT] = speed_code[1];
                    rdata_d[pcs_mgmt_pkg::CTRL_SPEED_LOW_BIT]  = speed_code[0];
                end
                pcs_mgmt_pkg::OFS_PCS_STATUS: begin
                    rdata_d = pcs_mgmt_pkg::STAT_FIXED_BITS;
                    rdata_d[pcs_mgmt_pkg::STAT_AUTONEG_DONE_BIT] = autoneg_complete;
                    rdata_d[pcs_mgmt_pkg::STAT_LINK_BIT]         = link_status;
                end
                pcs_mgmt_pkg::OFS_ADVERTISED:        rdata_d = adv_q;
                pcs_mgmt_pkg::OFS_PARTNER:           rdata_d = partner_ability_in;
                pcs_mgmt_pkg::OFS_AUTONEG_EXPANSION: rdata_d = autoneg_expansion_in;
                pcs_mgmt_pkg::OFS_EVENT_STATUS:      rdata_d = event_status;
                pcs_mgmt_pkg::OFS_EVENT_ENABLE:      rdata_d = event_enable;
                pcs_mgmt_pkg::OFS_EVENT_FORCE_SET:   rdata_d = 16'h0000;
                pcs_mgmt_pkg::OFS_CONFIG_SOURCE:     rdata_d = cfg_q;
                pcs_mgmt_pkg::OFS_EXTENDED_STATUS:   rdata_d = extended_status_in;
                pcs_mgmt_pkg::OFS_DEBUG_CONTROL_0:   rdata_d = dbg0_q;
                pcs_mgmt_pkg::OFS_DEBUG_CONTROL_1:   rdata_d = dbg1_q;
                pcs_mgmt_pkg::OFS_FIFO_STATUS:       rdata_d = fifo_state_in;
                pcs_mgmt_pkg::OFS_DEBUG_CONTROL_10:  rdata_d = dbg10_q;
                pcs_mgmt_pkg::OFS_DEBUG_CONTROL_11:  rdata_d = dbg11_q;
                default: begin
                    rdata_d = 16'h0000;
                    mapped  = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q  <= 16'h0000;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= rd_req;
            if (rd_req) begin
                rdata_q <= rdata_d;
            end
        end
    end

    assign mgmt_rdata_valid = rvalid_q;
    assign mgmt_rdata       = rdata_q;

    // Rate selection: gigabit mode always runs at one gigabit.
    always_comb begin
        if (gbe_mode) begin
            rate_d = pcs_mgmt_pkg::SPEED_1G;
        end else if (ctrl_q[pcs_mgmt_pkg::CTRL_AUTONEG_EN_BIT]) begin
            rate_d = {adv_q[pcs_mgmt_pkg::ADV_RATE_HIGH_BIT], adv_q[pcs_mgmt_pkg::ADV_RATE_LOW_BIT]};
        end else begin
            rate_d = speed_code;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rate_q <= pcs_mgmt_pkg::SPEED_10M;
        end else begin
            rate_q <= rate_d;
        end
    end

    assign mii_rate            = rate_q;
    assign core_reset          = ctrl_q[pcs_mgmt_pkg::CTRL_RESET_BIT];
    assign loopback_enable     = ctrl_q[pcs_mgmt_pkg::CTRL_LOOPBACK_BIT];
    assign power_down          = ctrl_q[pcs_mgmt_pkg::CTRL_POWER_DOWN_BIT];
    assign isolate             = ctrl_q[pcs_mgmt_pkg::CTRL_ISOLATE_BIT];
    assign autoneg_enable      = ctrl_q[pcs_mgmt_pkg::CTRL_AUTONEG_EN_BIT];
    assign autoneg_restart     = ctrl_q[pcs_mgmt_pkg::CTRL_RESTART_BIT];
    assign duplex_full         = ctrl_q[pcs_mgmt_pkg::CTRL_DUPLEX_BIT];
    assign collision_test      = ctrl_q[pcs_mgmt_pkg::CTRL_COLLISION_BIT];
    assign unidirectional      = ctrl_q[pcs_mgmt_pkg::CTRL_UNIDIR_BIT];
    assign advertised_ability  = adv_q;
    assign internal_config_sel = cfg_q[pcs_mgmt_pkg::CFG_SOURCE_BIT];
    assign debug_control_0     = dbg0_q;
    assign debug_control_1     = dbg1_q;
    assign debug_control_10    = dbg10_q;
    assign debug_control_11    = dbg11_q;

    for (genvar g = 0; g < pcs_mgmt_pkg::RECOVERY_COUNT; g++) begin : g_recovery
        assign recovery_config[g*16 +: 16] = recovery_q[g];
    end

    property p_unmapped_zero;
        @(posedge clk) disable iff (rst)
        (rd_req && !mapped) |=> (mgmt_rdata_valid && mgmt_rdata == 16'h0000);
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");

    property p_reserved_zero;
        @(posedge clk) disable iff (rst)
        (rd_req && hit(mgmt_offset, pcs_mgmt_pkg::OFS_PCS_CONTROL)) |=> (mgmt_rdata[4:0] == 5'h00);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved control bits not zero");

    property p_reset_self_clears;
        @(posedge clk) disable iff (rst)
        (wr_req && hit(mgmt_offset, pcs_mgmt_pkg::OFS_PCS_CONTROL) && mgmt_wdata[15])
        |=> core_reset ##1 (!core_reset || $past(wr_req));
    endproperty
    a_reset_self_clears: assert property (p_reset_self_clears) else $error("core reset not a single pulse");

    property p_restart_self_clears;
        @(posedge clk) disable iff (rst)
        (autoneg_restart && !(wr_req && hit(mgmt_offset, pcs_mgmt_pkg::OFS_PCS_CONTROL))) |=> !autoneg_restart;
    endproperty
    a_restart_self_clears: assert property (p_restart_self_clears) else $error("restart bit stuck");

    property p_gbe_speed_read;
        @(posedge clk) disable iff (rst)
        (rd_req && gbe_mode && hit(mgmt_offset, pcs_mgmt_pkg::OFS_PCS_CONTROL))
        |=> (mgmt_rdata[6] && !mgmt_rdata[13]);
    endproperty
    a_gbe_speed_read: assert property (p_gbe_speed_read) else $error("gigabit speed code not forced");

    property p_rate_follows_adv;
        @(posedge clk) disable iff (rst)
        (!gbe_mode && autoneg_enable) |=> (mii_rate == $past(adv_q[11:10]));
    endproperty
    a_rate_follows_adv: assert property (p_rate_follows_adv) else $error("rate ignores advertised bits");

    property p_rate_follows_speed;
        @(posedge clk) disable iff (rst)
        (!gbe_mode && !autoneg_enable) |=> (mii_rate == {$past(ctrl_q[6]), $past(ctrl_q[13])});
    endproperty
    a_rate_follows_speed: assert property (p_rate_follows_speed) else $error("rate ignores speed field");

    property p_loopback_write;
        @(posedge clk) disable iff (rst)
        (wr_req && hit(mgmt_offset, pcs_mgmt_pkg::OFS_PCS_CONTROL))
        |=> (loopback_enable == $past(mgmt_wdata[14]) && power_down == $past(mgmt_wdata[11]));
    endproperty
    a_loopback_write: assert property (p_loopback_write) else $error("control write not applied");

    property p_config_select;
        @(posedge clk) disable iff (rst)
        (wr_req && hit(mgmt_offset, pcs_mgmt_pkg::OFS_CONFIG_SOURCE))
        |=> (internal_config_sel == $past(mgmt_wdata[0]));
    endproperty
    a_config_select: assert property (p_config_select) else $error("config source select not applied");

endmodule
`default_nettype wire

// ==== verification/mgmt_host.sv ====
// Host model that issues requests on the management port of the register bank.
// Assumes the bank never stalls, so each request is held for exactly one edge.
`timescale 1ns/1ns
`default_nettype none
module mgmt_host (
    input  wire logic        clk,
    output logic             request,
    output logic             write,
    output logic      [8:0]  offset,
    output logic      [15:0] wdata
);
    initial begin
        request = 1'b0;
        write   = 1'b0;
        offset  = 9'h000;
        wdata   = 16'h0000;
    end
    task automatic access(input logic w, input logic [8:0] o, input logic [15:0] d);
        @(negedge clk);
        request = 1'b1;
        write   = w;
        offset  = o;
        wdata   = d;
        @(negedge clk);
        // Leftovers are inverted so a stale bus never looks like a live request.
        request = 1'b0;
        offset  = ~o;
        wdata   = ~d;
    endtask
endmodule
`default_nettype wire

// ==== verification/testbench.sv ====
// Self-checking bench for the PCS management register bank.
// Assumes mgmt_host drives the management port; reads are checked from a queue.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic        clk = 0, rst = 1, gbe = 0, lnk = 1, req, wen, rdv, rc, lb, pd, iso, ane, cfg, flg;
    logic [15:0] ro = 16'h0000, ev = 16'h0000, rv, wd, rd;
    logic        rdy, rs, dup, col, uni;
    logic [15:0] advo, d0, d1, d10, d11;
    logic [207:0] rcfg;
    logic [8:0]  ros[4] = '{9'h005, 9'h006, 9'h00f, 9'h109};
    logic [8:0]  ofs;
    logic [1:0]  rate;
    logic [15:0] expq[$];
    logic [8:0]  rw[9] = '{9'h004, 9'h009, 9'h00e, 9'h010, 9'h01c, 9'h100, 9'h101, 9'h10a, 9'h10b};
    int          failures = 0, cmp_count = 0, cyc = 0;
    always #5 clk = ~clk;
    mgmt_host mgmt_host_inst (.clk(clk), .request(req), .write(wen), .offset(ofs), .wdata(wd));
    pcs_management_registers pcs_management_registers_inst (.clk(clk), .rst(rst), .mgmt_request(req),
        .mgmt_write(wen), .mgmt_offset(ofs), .mgmt_wdata(wd), .mgmt_ready(rdy), .mgmt_rdata_valid(rdv),
        .mgmt_rdata(rd), .gbe_mode(gbe), .link_up(lnk), .autoneg_complete(1'b0), .partner_ability_in(ro),
        .autoneg_expansion_in(ro), .extended_status_in(ro), .fifo_state_in(ro), .core_events(ev),
        .core_reset(rc), .loopback_enable(lb), .power_down(pd), .isolate(iso), .autoneg_enable(ane),
        .autoneg_restart(rs), .duplex_full(dup), .collision_test(col), .unidirectional(uni), .mii_rate(rate),
        .advertised_ability(advo), .internal_config_sel(cfg), .events_flagged(flg), .recovery_config(rcfg),
        .debug_control_0(d0), .debug_control_1(d1), .debug_control_10(d10), .debug_control_11(d11));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("Error %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic put_reg(input logic [8:0] o, input logic [15:0] d);
        mgmt_host_inst.access(1'b1, o, d);
    endtask
    task automatic get_reg(input logic [8:0] o, input logic [15:0] e);
        expq.push_back(e);
        mgmt_host_inst.access(1'b0, o, 16'h0000);
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Read data is judged at the falling edge, where it has long settled.
    // An unexpected read answer finds no note and is counted as a mismatch.
    always @(negedge clk) if (rdv === 1'b1) chk(rd, expq.size() > 0 ? expq.pop_front() : ~rd);
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            wrap_up();
        end
    end
    initial begin
        void'($urandom(44));
        repeat (2) @(negedge clk);
        rst = 1'b0;
        foreach (rw[i]) begin
            rv = 16'($urandom);
            put_reg(rw[i], rv);
            case (i)
                0: chk(advo, rv);
                2: chk(16'(cfg), 16'(rv[0]));
                3: chk(rcfg[15:0], rv);
                4: chk(rcfg[207:192], rv);
                5: chk(d0, rv);
                6: chk(d1, rv);
                7: chk(d10, rv);
                8: chk(d11, rv);
                default: chk({15'h0000, rdy}, 16'h0001);
            endcase
            get_reg(rw[i], rv);
        end
        put_reg(9'h00e, 16'h0001);
        chk(16'(cfg), 16'h0001);
        ro = 16'($urandom);
        foreach (ros[i]) put_reg(ros[i], ~ro);
        foreach (ros[i]) get_reg(ros[i], ro);
        put_reg(9'h1ff, 16'hffff);
        get_reg(9'h1ff, 16'h0000);
        $display("register map test done");
        get_reg(9'h001, 16'h0188);
        get_reg(9'h001, 16'h018c);
        lnk = 1'b0;
        @(negedge clk) lnk = 1'b1;
        get_reg(9'h001, 16'h0188);
        get_reg(9'h001, 16'h018c);
        $display("link test done");
        put_reg(9'h000, 16'h2040);
        @(negedge clk) chk(16'(rate), 16'h0003);
        get_reg(9'h000, 16'h2040);
        gbe = 1'b1;
        get_reg(9'h000, 16'h0040);
        chk(16'(rate), 16'h0002);
        gbe = 1'b0;
        put_reg(9'h004, 16'h0400);
        put_reg(9'h000, 16'h5da0);
        chk({9'h000, lb, ane, pd, iso, dup, col, uni}, 16'h007f);
        @(negedge clk) chk(16'(rate), 16'h0001);
        put_reg(9'h000, 16'h8200);
        chk({14'h0000, rc, rs}, 16'h0003);
        get_reg(9'h000, 16'h0000);
        $display("control test done");
        put_reg(9'h008, 16'hffff);
        put_reg(9'h009, 16'h0000);
        ev = 16'h0010;
        @(negedge clk) ev = 16'h0000;
        get_reg(9'h008, 16'h0010);
        put_reg(9'h00a, 16'h0300);
        get_reg(9'h008, 16'h0310);
        chk({15'h0000, flg}, 16'h0000);
        put_reg(9'h009, 16'h0100);
        repeat (2) @(negedge clk);
        chk({15'h0000, flg}, 16'h0001);
        $display("event test done");
        repeat (3) @(negedge clk);
        wrap_up();
    end
endmodule
`default_nettype wire
